/* design/itc_conditioner.sv */
/*
 Input terminal conditioner: polarity, sampling filter, per-terminal delays, virtual
 terminals and function decoding, with an AXI4-Lite register slave.
 Assumes terminal pins are asynchronous and external logic uses the decoded commands.
*/
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "itc_defines.svh"

module itc_conditioner #(
	parameter int NUM_TERM = 9,
	parameter int TICK_CYCLES = `ITC_TICK_CYCLES
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [8:0] TERMINAL_PINS,
	input wire logic [7:0] S_AWADDR,
	input wire logic S_AWVALID,
	output logic S_AWREADY,
	input wire logic [31:0] S_WDATA,
	input wire logic [3:0] S_WSTRB,
	input wire logic S_WVALID,
	output logic S_WREADY,
	output logic [1:0] S_BRESP,
	output logic S_BVALID,
	input wire logic S_BREADY,
	input wire logic [7:0] S_ARADDR,
	input wire logic S_ARVALID,
	output logic S_ARREADY,
	output logic [31:0] S_RDATA,
	output logic [1:0] S_RRESP,
	output logic S_RVALID,
	input wire logic S_RREADY,
	output logic [8:0] TERMINAL_STATE,
	output logic [1:0] CONTROL_MODE,
	output logic HS_PULSE_INPUT,
	output itc_pkg::itc_cmd_type COMMANDS
);

	logic [8:0] sync1_q;
	logic [8:0] sync2_q;
	logic [8:0] polarity_q;
	logic [15:0] filter_q;
	logic [8:0] virt_en_q;
	logic [1:0] mode_q;
	logic hs_type_q;
	logic [8:0] virt_state_q;
	logic [6:0] func_q [NUM_TERM];
	logic [15:0] on_q [NUM_TERM];
	logic [15:0] off_q [NUM_TERM];
	logic [15:0] tick_cnt_q;
	logic tick_q;
	logic [8:0] raw;
	logic [8:0] filt_q;
	logic [15:0] fcnt_q [NUM_TERM];
	logic [8:0] eff_q;
	logic [15:0] dcnt_q [NUM_TERM];
	logic [8:0] eff_prev_q;
	itc_pkg::itc_bus_state_type st_q;
	logic aw_got_q;
	logic w_got_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [7:0] araddr_q;
	logic wr_go;
	logic [31:0] rd_word;
	logic rd_ok;
	logic wr_ok;
	int widx;
	int ridx;

	// Pins are asynchronous to the clock.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			sync1_q <= 9'h000;
			sync2_q <= 9'h000;
		end
		else
		begin
			sync1_q <= TERMINAL_PINS;
			sync2_q <= sync1_q;
		end
	end

	// Virtual terminals ignore their pin; terminals five to eight have no pin at all.
	always_comb
	begin
		raw = (sync2_q & `ITC_PHYS_MASK & ~virt_en_q) | (virt_state_q & virt_en_q);
		raw = raw ^ polarity_q;
	end

	// One millisecond tick paces both the filter and the delays.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else if (tick_cnt_q == 16'(TICK_CYCLES - 1))
		begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b1;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// A level is accepted only after staying different from the filtered one for
	// the whole filter time; any bounce restarts the count.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			filt_q <= 9'h000;
			for (int i = 0; i < NUM_TERM; i++)
				fcnt_q[i] <= 16'h0000;
		end
		else
		begin
			for (int i = 0; i < NUM_TERM; i++)
			begin
				if (raw[i] == filt_q[i])
					fcnt_q[i] <= 16'h0000;
				else if (fcnt_q[i] >= filter_q)
				begin
					filt_q[i] <= raw[i];
					fcnt_q[i] <= 16'h0000;
				end
				else if (tick_q)
					fcnt_q[i] <= fcnt_q[i] + 16'h0001;
			end
		end
	end

	// Switch-on delay applies to rising changes, switch-off delay to falling ones.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			eff_q <= 9'h000;
			for (int i = 0; i < NUM_TERM; i++)
				dcnt_q[i] <= 16'h0000;
		end
		else
		begin
			for (int i = 0; i < NUM_TERM; i++)
			begin
				if (filt_q[i] == eff_q[i])
					dcnt_q[i] <= 16'h0000;
				else if (dcnt_q[i] >= (filt_q[i] ? on_q[i] : off_q[i]))
				begin
					eff_q[i] <= filt_q[i];
					dcnt_q[i] <= 16'h0000;
				end
				else if (tick_q)
					dcnt_q[i] <= dcnt_q[i] + 16'h0001;
			end
		end
	end

	// Decode the selected functions; reserved codes match no case and do nothing.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			COMMANDS <= '0;
			eff_prev_q <= 9'h000;
		end
		else
		begin
			itc_pkg::itc_cmd_type c;
			logic [8:0] use_t;
			c = '0;
			use_t = eff_q;
			if (hs_type_q != `ITC_HS_TYPE_DIGITAL)
				use_t[8] = 1'b0;
			for (int i = 0; i < NUM_TERM; i++)
			begin
				if (use_t[i])
				begin
					case (func_q[i])
						`ITC_CODE_CH_KEYPAD:
						begin
							c.channel = itc_pkg::ITC_CH_KEYPAD;
							c.channel_valid = 1'b1;
						end
						`ITC_CODE_CH_TERMINAL:
						begin
							c.channel = itc_pkg::ITC_CH_TERMINAL;
							c.channel_valid = 1'b1;
						end
						`ITC_CODE_CH_COMM:
						begin
							c.channel = itc_pkg::ITC_CH_COMM;
							c.channel_valid = 1'b1;
						end
						`ITC_CODE_PREEXCITE: c.preexcite = 1'b1;
						`ITC_CODE_CLR_ENERGY: c.clear_energy = 1'b1;
						`ITC_CODE_HOLD_ENERGY: c.hold_energy = 1'b1;
						`ITC_CODE_BRAKE_KEYPAD: c.brake_keypad = 1'b1;
						`ITC_CODE_PID_INVERT: c.pid_invert = 1'b1;
						`ITC_CODE_ESTOP: c.estop = !eff_prev_q[i];
						default: c = c;
					endcase
				end
			end
			COMMANDS <= c;
			eff_prev_q <= use_t;
		end
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			TERMINAL_STATE <= 9'h000;
			CONTROL_MODE <= `ITC_MODE_RST;
			HS_PULSE_INPUT <= 1'b1;
		end
		else
		begin
			TERMINAL_STATE <= eff_q;
			CONTROL_MODE <= mode_q;
			HS_PULSE_INPUT <= (hs_type_q != `ITC_HS_TYPE_DIGITAL);
		end
	end

	// Register slave. Address and data are taken in either order; one access at a time.
	assign wr_go = aw_got_q && w_got_q && (st_q == itc_pkg::ITC_IDLE);
	assign widx = (int'(awaddr_q) - int'(`ITC_OFF_FUNC_BASE)) / 4;
	assign wr_ok = (awaddr_q[1:0] == 2'h0) && (awaddr_q <= `ITC_OFF_LAST);

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			st_q <= itc_pkg::ITC_IDLE;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			araddr_q <= 8'h00;
			S_AWREADY <= 1'b0;
			S_WREADY <= 1'b0;
			S_ARREADY <= 1'b0;
			S_BVALID <= 1'b0;
			S_BRESP <= 2'h0;
			S_RVALID <= 1'b0;
			S_RRESP <= 2'h0;
			S_RDATA <= 32'h0000_0000;
		end
		else
		begin
			S_AWREADY <= 1'b0;
			S_WREADY <= 1'b0;
			S_ARREADY <= 1'b0;
			unique case (st_q)
				itc_pkg::ITC_IDLE:
				begin
					if (wr_go)
					begin
						S_BVALID <= 1'b1;
						S_BRESP <= wr_ok ? 2'h0 : 2'h2;
						aw_got_q <= 1'b0;
						w_got_q <= 1'b0;
						st_q <= itc_pkg::ITC_WRESP;
					end
					else if (S_ARVALID && !S_ARREADY && !aw_got_q && !w_got_q)
					begin
						S_ARREADY <= 1'b1;
						araddr_q <= S_ARADDR;
						st_q <= itc_pkg::ITC_READ;
					end
					else
					begin
						if (S_AWVALID && !aw_got_q && !S_AWREADY)
						begin
							S_AWREADY <= 1'b1;
							awaddr_q <= S_AWADDR;
							aw_got_q <= 1'b1;
						end
						if (S_WVALID && !w_got_q && !S_WREADY)
						begin
							S_WREADY <= 1'b1;
							wdata_q <= S_WDATA;
							wstrb_q <= S_WSTRB;
							w_got_q <= 1'b1;
						end
					end
				end
				itc_pkg::ITC_READ:
				begin
					S_RVALID <= 1'b1;
					S_RDATA <= rd_word;
					S_RRESP <= rd_ok ? 2'h0 : 2'h2;
					st_q <= itc_pkg::ITC_RRESP;
				end
				itc_pkg::ITC_WRESP:
				begin
					if (S_BREADY)
					begin
						S_BVALID <= 1'b0;
						st_q <= itc_pkg::ITC_IDLE;
					end
				end
				itc_pkg::ITC_RRESP:
				begin
					if (S_RREADY)
					begin
						S_RVALID <= 1'b0;
						st_q <= itc_pkg::ITC_IDLE;
					end
				end
			endcase
		end
	end

	// Filter time and delays are clamped to their legal ranges so a stray write cannot stretch timing.
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			polarity_q <= `ITC_POLARITY_RST;
			filter_q <= `ITC_FILTER_RST;
			virt_en_q <= `ITC_VIRT_EN_RST;
			mode_q <= `ITC_MODE_RST;
			hs_type_q <= `ITC_HS_TYPE_RST;
			virt_state_q <= 9'h000;
			for (int i = 0; i < NUM_TERM; i++)
			begin
				func_q[i] <= 7'h00;
				on_q[i] <= `ITC_DELAY_RST;
				off_q[i] <= `ITC_DELAY_RST;
			end
		end
		else if (wr_go && wr_ok && (wstrb_q[1:0] == 2'h3))
		begin
			if (awaddr_q == `ITC_OFF_POLARITY)
				polarity_q <= wdata_q[8:0];
			else if (awaddr_q == `ITC_OFF_FILTER)
				filter_q <= (wdata_q[15:0] > `ITC_FILTER_MAX) ? `ITC_FILTER_MAX : wdata_q[15:0];
			else if (awaddr_q == `ITC_OFF_VIRT_EN)
				virt_en_q <= wdata_q[8:0];
			else if (awaddr_q == `ITC_OFF_MODE)
				mode_q <= wdata_q[1:0];
			else if (awaddr_q == `ITC_OFF_HS_TYPE)
				hs_type_q <= wdata_q[0];
			else if (awaddr_q == `ITC_OFF_VIRT_STATE)
				virt_state_q <= wdata_q[8:0];
			else if (awaddr_q >= `ITC_OFF_OFF_BASE)
				off_q[widx - 20] <= (wdata_q[15:0] > `ITC_DELAY_MAX) ? `ITC_DELAY_MAX : wdata_q[15:0];
			else if (awaddr_q >= `ITC_OFF_ON_BASE)
				on_q[widx - 20 + 10] <= (wdata_q[15:0] > `ITC_DELAY_MAX) ? `ITC_DELAY_MAX : wdata_q[15:0];
			else if (awaddr_q >= `ITC_OFF_FUNC_BASE && widx < NUM_TERM)
				func_q[widx] <= wdata_q[6:0];
		end
	end

	assign ridx = (int'(araddr_q) - int'(`ITC_OFF_FUNC_BASE)) / 4;
	assign rd_ok = (araddr_q[1:0] == 2'h0) && (araddr_q <= `ITC_OFF_LAST);

	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (araddr_q == `ITC_OFF_POLARITY)
			rd_word[8:0] = polarity_q;
		else if (araddr_q == `ITC_OFF_FILTER)
			rd_word[15:0] = filter_q;
		else if (araddr_q == `ITC_OFF_VIRT_EN)
			rd_word[8:0] = virt_en_q;
		else if (araddr_q == `ITC_OFF_MODE)
			rd_word[1:0] = mode_q;
		else if (araddr_q == `ITC_OFF_HS_TYPE)
			rd_word[0] = hs_type_q;
		else if (araddr_q == `ITC_OFF_VIRT_STATE)
			rd_word[8:0] = virt_state_q;
		else if (araddr_q == `ITC_OFF_STATUS)
			rd_word[8:0] = eff_q;
		else if (araddr_q == `ITC_OFF_COMMANDS)
			rd_word[8:0] = COMMANDS;
		else if (rd_ok && araddr_q >= `ITC_OFF_OFF_BASE)
			rd_word[15:0] = off_q[ridx - 20];
		else if (rd_ok && araddr_q >= `ITC_OFF_ON_BASE)
			rd_word[15:0] = on_q[ridx - 10];
		else if (rd_ok && araddr_q >= `ITC_OFF_FUNC_BASE && ridx < NUM_TERM)
			rd_word[6:0] = func_q[ridx];
	end

	a_virt_ignores_pin: assert property (@(posedge CLK) disable iff (!RESETN)
		(virt_en_q[0] && $stable(virt_en_q)) |-> raw[0] == (virt_state_q[0] ^ polarity_q[0]))
		else $error("Virtual terminal followed its pin.");
	a_pin_five_none: assert property (@(posedge CLK) disable iff (!RESETN)
		!virt_en_q[4] |-> raw[4] == polarity_q[4])
		else $error("Terminal five read a pin.");
	a_filter_stable: assert property (@(posedge CLK) disable iff (!RESETN)
		$changed(filt_q[0]) |-> $past(fcnt_q[0]) >= $past(filter_q))
		else $error("Filter accepted level early.");
	a_filter_range: assert property (@(posedge CLK) disable iff (!RESETN)
		filter_q <= `ITC_FILTER_MAX)
		else $error("Filter time out of range.");
	a_delay_range: assert property (@(posedge CLK) disable iff (!RESETN)
		on_q[0] <= `ITC_DELAY_MAX && off_q[0] <= `ITC_DELAY_MAX)
		else $error("Delay out of range.");
	a_on_delay_met: assert property (@(posedge CLK) disable iff (!RESETN)
		$rose(eff_q[0]) |-> $past(dcnt_q[0]) >= on_q[0])
		else $error("Switch-on delay cut short.");
	a_estop_edge: assert property (@(posedge CLK) disable iff (!RESETN)
		COMMANDS.estop |=> !COMMANDS.estop || $rose(eff_q))
		else $error("Emergency stop held over.");
	a_mode_follows: assert property (@(posedge CLK) disable iff (!RESETN)
		$changed(mode_q) |=> CONTROL_MODE == $past(mode_q))
		else $error("Control mode lagged.");
	a_hs_gated: assert property (@(posedge CLK) disable iff (!RESETN)
		(hs_type_q != `ITC_HS_TYPE_DIGITAL && $stable(hs_type_q)) |=> !eff_prev_q[8])
		else $error("Pulse input acted as terminal.");
	c_estop: cover property (@(posedge CLK) disable iff (!RESETN) COMMANDS.estop);
	c_channel: cover property (@(posedge CLK) disable iff (!RESETN) COMMANDS.channel_valid);
	c_virtual: cover property (@(posedge CLK) disable iff (!RESETN) virt_en_q[0] && eff_q[0]);

endmodule : itc_conditioner

/* design/itc_defines.svh */
/*
 Constants for the input terminal conditioner: register byte offsets, reset values,
 function codes and timing figures.
 Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
// Notes on behaviour
// - Codes 36/37/38 select keypad, terminal, communication channel.
// - 39 pre-excite, 40 clear, 41 hold consumption.
// - 42 moves braking limit source to keypad.
// - Code 56 triggers emergency stop on activation.
// - 61 inverts PID sense; 62-95 do nothing.
// - Codes 35, 43-55, 57-60 do nothing.
// - Terminals five to eight exist only virtually.
// - Virtual terminals follow communication writes, ignore pins.
// - Polarity bit one inverts terminal; resets zero.
// - One filter time, 0 to 1 s, 10 ms.
// - Virtual enable bits 0-8 map terminals, reset zero.
// - Mode 0-3: two-wire 1,2; three-wire 1,2.
// - Switch-on and switch-off delays per terminal.
// - Delays 0 to 50 s in ms, reset zero.
// - High-speed input is digital only when type is 1.
`ifndef ITC_DEFINES_SVH
`define ITC_DEFINES_SVH

`define ITC_OFF_POLARITY 8'h00
`define ITC_OFF_FILTER 8'h04
`define ITC_OFF_VIRT_EN 8'h08
`define ITC_OFF_MODE 8'h0C
`define ITC_OFF_HS_TYPE 8'h10
`define ITC_OFF_VIRT_STATE 8'h14
`define ITC_OFF_STATUS 8'h18
`define ITC_OFF_COMMANDS 8'h1C
`define ITC_OFF_FUNC_BASE 8'h20
`define ITC_OFF_ON_BASE 8'h48
`define ITC_OFF_OFF_BASE 8'h70
`define ITC_OFF_LAST 8'h90

`define ITC_POLARITY_RST 9'h000
`define ITC_VIRT_EN_RST 9'h000
`define ITC_MODE_RST 2'h0
`define ITC_FILTER_RST 16'h000A
`define ITC_FILTER_MAX 16'h03E8
`define ITC_DELAY_MAX 16'hC350
`define ITC_DELAY_RST 16'h0000
`define ITC_HS_TYPE_RST 1'h0
`define ITC_HS_TYPE_DIGITAL 1'h1
`define ITC_PHYS_MASK 9'h10F

`define ITC_CODE_CH_KEYPAD 7'h24
`define ITC_CODE_CH_TERMINAL 7'h25
`define ITC_CODE_CH_COMM 7'h26
`define ITC_CODE_PREEXCITE 7'h27
`define ITC_CODE_CLR_ENERGY 7'h28
`define ITC_CODE_HOLD_ENERGY 7'h29
`define ITC_CODE_BRAKE_KEYPAD 7'h2A
`define ITC_CODE_ESTOP 7'h38
`define ITC_CODE_PID_INVERT 7'h3D

`define ITC_CLK_HZ 10000000
`define ITC_TICK_MS 1
`define ITC_TICK_CYCLES ((`ITC_CLK_HZ / 1000) * `ITC_TICK_MS)

`endif

/* design/itc_pkg.sv */
/*
 Types shared by the input terminal conditioner.
 Assumes the constants header is compiled alongside.
*/
package itc_pkg;

	typedef struct packed {
		logic [1:0] channel;
		logic channel_valid;
		logic preexcite;
		logic clear_energy;
		logic hold_energy;
		logic brake_keypad;
		logic estop;
		logic pid_invert;
	} itc_cmd_type;

	typedef enum logic [3:0] {
		ITC_IDLE = 4'h1,
		ITC_READ = 4'h2,
		ITC_WRESP = 4'h4,
		ITC_RRESP = 4'h8
	} itc_bus_state_type;

	typedef enum logic [1:0] {
		ITC_CH_KEYPAD = 2'h0,
		ITC_CH_TERMINAL = 2'h1,
		ITC_CH_COMM = 2'h2
	} itc_channel_type;

endpackage : itc_pkg

/* tb/itc_switch_model.sv */
/*
 External contacts on the terminal pins, with optional chatter on terminal one.
 Assumes the bench gives the wanted levels and orders chatter only on purpose.
*/
`timescale 1ns/1ps

module itc_switch_model
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [8:0] level_req,
	input wire logic bounce,
	output logic [8:0] pins
);
	// Positions four to seven have no pin, so they float with a changing pattern.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pins <= 9'h000;
		else
			pins <= {level_req[8], ~pins[7:4], level_req[3:1], bounce ? ~pins[0] : level_req[0]};
	end
endmodule : itc_switch_model

/* tb/input_terminal_conditioner_tb.sv */
/*
 Self-checking bench for the terminal conditioner: registers, pin path, virtual terminals, decode.
 Assumes a one-millisecond tick of ten cycles and the register map of the defines header.
*/
`timescale 1ns/1ps
`include "itc_defines.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end

module input_terminal_conditioner_tb;
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} itc_row_type;
	logic CLK = 0, RESETN = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic bounce = 0;
	logic [8:0] level_req = 9'h000, pins, tstate;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic [1:0] bresp, rresp, cmode, rr;
	logic awready, wready, bvalid, arready, rvalid, hs;
	itc_pkg::itc_cmd_type cmds;
	int failures = 0, compares = 0, n, i;
	itc_row_type rows [12] = '{
		'{`ITC_OFF_POLARITY, 0, 0, 32'h0}, '{`ITC_OFF_FILTER, 0, 0, 32'hA},
		'{`ITC_OFF_VIRT_EN, 0, 0, 32'h0}, '{`ITC_OFF_MODE, 0, 0, 32'h0},
		'{`ITC_OFF_HS_TYPE, 0, 0, 32'h0}, '{`ITC_OFF_ON_BASE, 0, 0, 32'h0},
		'{`ITC_OFF_POLARITY, 1, 32'h1FF, 32'h1FF}, '{`ITC_OFF_FILTER, 1, 32'h2000, 32'h3E8},
		'{`ITC_OFF_VIRT_EN, 1, 32'h1FF, 32'h1FF}, '{`ITC_OFF_MODE, 1, 32'h3, 32'h3},
		'{`ITC_OFF_ON_BASE, 1, 32'hFFFF, 32'hC350}, '{8'h90, 1, 32'hC350, 32'hC350}};
	logic [6:0] codes [16] = '{36, 35, 37, 43, 38, 55, 39, 57, 40, 60, 41, 62, 42, 95, 61, 0};
	logic [8:0] exps [16] = '{9'h040, 0, 9'h0C0, 0, 9'h140, 0, 9'h020, 0, 9'h010, 0,
		9'h008, 0, 9'h004, 0, 9'h001, 0};

	always #50 CLK = ~CLK;

	itc_switch_model sw_u (.clk(CLK), .resetn(RESETN), .level_req(level_req), .bounce(bounce),
		.pins(pins));
	itc_conditioner #(.TICK_CYCLES(10)) dut_u (.CLK(CLK), .RESETN(RESETN), .TERMINAL_PINS(pins),
		.S_AWADDR(awaddr), .S_AWVALID(awvalid), .S_AWREADY(awready), .S_WDATA(wdata),
		.S_WSTRB(4'hF), .S_WVALID(wvalid), .S_WREADY(wready), .S_BRESP(bresp),
		.S_BVALID(bvalid), .S_BREADY(bready), .S_ARADDR(araddr), .S_ARVALID(arvalid),
		.S_ARREADY(arready), .S_RDATA(rdata), .S_RRESP(rresp), .S_RVALID(rvalid),
		.S_RREADY(rready), .TERMINAL_STATE(tstate), .CONTROL_MODE(cmode),
		.HS_PULSE_INPUT(hs), .COMMANDS(cmds));

	task automatic close_out;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	task automatic tmo(input int k);
		if (k >= 50)
		begin
			failures++;
			close_out();
		end
	endtask : tmo

	// The response is awaited after release, so it is never taken while bready is low.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		logic awp;
		logic wp;
		@(posedge CLK);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		awp = 1;
		wp = 1;
		k = 0;
		while ((awp || wp) && k < 50)
		begin
			@(posedge CLK);
			k++;
			if (awp && awready)
			begin
				awp = 0;
				awvalid <= 0;
			end
			if (wp && wready)
			begin
				wp = 0;
				wvalid <= 0;
			end
		end
		tmo(k);
		bready <= 1;
		k = 0;
		do begin @(posedge CLK); k++; end while (bvalid !== 1 && k < 50);
		tmo(k);
		bready <= 0;
		`CHK("bresp", er, bresp)
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge CLK);
		araddr <= a;
		arvalid <= 1;
		for (k = 0; k < 50 && !(arvalid && arready); k++)
			@(posedge CLK);
		tmo(k);
		arvalid <= 0;
		rready <= 1;
		k = 0;
		do begin @(posedge CLK); k++; end while (rvalid !== 1 && k < 50);
		tmo(k);
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask : rd

	task automatic twait(input int t, input logic v, input int lim);
		for (n = 0; n < lim && tstate[t] !== v; n++)
			@(posedge CLK);
	endtask : twait

	task automatic cwait(input logic [8:0] e);
		for (n = 0; n < 40 && cmds !== e; n++)
			@(posedge CLK);
		`CHK("cmds", e, cmds)
	endtask : cwait

	initial
	begin
		repeat (5) @(posedge CLK);
		RESETN <= 1;
		`CHK("hs", 1'b1, hs)
		for (i = 0; i < 12; i++)
		begin
			if (rows[i].w) wr(rows[i].a, rows[i].d, 2'h0);
			rd(rows[i].a, rv, rr);
			`CHK("reg", rows[i].e, rv)
		end
		for (i = 0; i < 4; i++)
		begin
			wr(`ITC_OFF_MODE, i, 2'h0);
			repeat (2) @(posedge CLK);
			`CHK("mode", i[1:0], cmode)
		end
		wr(8'hFC, 32'h5, 2'h2);
		rd(8'hFC, rv, rr);
		`CHK("unmapped", 34'h2_0000_0000, {rr, rv})
		wr(`ITC_OFF_HS_TYPE, 32'h1, 2'h0);
		repeat (3) @(posedge CLK);
		`CHK("hs", 1'b0, hs)
		wr(`ITC_OFF_VIRT_EN, 32'h0, 2'h0);
		wr(`ITC_OFF_POLARITY, 32'h2, 2'h0);
		wr(`ITC_OFF_FILTER, 32'h2, 2'h0);
		wr(`ITC_OFF_ON_BASE, 32'h3, 2'h0);
		wr(`ITC_OFF_OFF_BASE, 32'h1, 2'h0);
		twait(1, 1, 200);
		`CHK("inverted", 1'b1, tstate[1])
		// Chatter never stays put long enough for the filter to pass it on.
		level_req[0] <= 1;
		bounce <= 1;
		repeat (80) @(posedge CLK);
		`CHK("chatter", 1'b0, tstate[0])
		bounce <= 0;
		twait(0, 1, 200);
		`CHK("on_time", 1'b1, n >= 30 && n <= 90)
		wr(`ITC_OFF_VIRT_EN, 32'h11, 2'h0);
		wr(`ITC_OFF_VIRT_STATE, 32'h0, 2'h0);
		twait(0, 0, 200);
		`CHK("virt_low", 1'b0, tstate[0])
		wr(`ITC_OFF_VIRT_STATE, 32'h11, 2'h0);
		twait(4, 1, 200);
		`CHK("virt_five", 2'h3, tstate[4:3] ^ 2'h1)
		for (i = 0; i < 16; i++)
		begin
			wr(8'h30, codes[i], 2'h0);
			cwait(exps[i]);
		end
		wr(`ITC_OFF_VIRT_STATE, 32'h0, 2'h0);
		wr(8'h30, 32'h38, 2'h0);
		twait(4, 0, 200);
		wr(`ITC_OFF_VIRT_STATE, 32'h10, 2'h0);
		cwait(9'h002);
		wr(`ITC_OFF_VIRT_EN, 32'h0, 2'h0);
		twait(0, 1, 200);
		`CHK("pin_again", 1'b1, tstate[0])
		level_req[0] <= 0;
		twait(0, 0, 200);
		`CHK("off_time", 1'b1, n >= 10 && n <= 60)
		close_out();
	end
endmodule : input_terminal_conditioner_tb
